// *** verilog/csdma_map.svh ***
// register map, field positions and reset values of the converter-scan dma
// assumes byte addresses on a 12-bit register-file page, word-aligned on axi
`ifndef CSDMA_MAP_SVH
`define CSDMA_MAP_SVH
// printed offsets are not all multiples of four: they are indices
`define CSDMA_IDX_CH0_END 12'hfb4
`define CSDMA_IDX_CH1_END 12'hfbc
`define CSDMA_IDX_BASE 12'hfbd
`define CSDMA_IDX_CTRL 12'hfbe
`define CSDMA_IDX_STAT 12'hfbf
// own registers: high nibbles, interrupt mask, masked status copy
`define CSDMA_IDX_END_HI 12'hfc0
`define CSDMA_IDX_IMASK 12'hfc1
`define CSDMA_IDX_IPEND 12'hfc2
`define CSDMA_CTRL_EN 7
`define CSDMA_CTRL_IE 6
`define CSDMA_CTRL_RESET 8'h00
`define CSDMA_STAT_SCAN 2
`define CSDMA_STAT_CH1 1
`define CSDMA_STAT_CH0 0
`define CSDMA_MAX_INPUT 4'hb
`endif

// *** verilog/csdma_pkg.sv ***
// types shared by the converter-scan dma files
package csdma_pkg;
    typedef enum logic [4:0] {
        CS_IDLE = 5'b00001,
        CS_CONV = 5'b00010,
        CS_WAIT = 5'b00100,
        CS_WR_HI = 5'b01000,
        CS_WR_LO = 5'b10000
    } csdma_state_t;
    typedef struct packed {
        logic valid;
        logic [11:0] addr;
        logic [7:0] data;
    } csdma_wr_t;
    typedef struct packed {
        logic start;
        logic [3:0] input_sel;
    } csdma_conv_t;
endpackage : csdma_pkg

// *** verilog/csdma_seq.sv ***
// scan sequencer: steps converter inputs and stores results as byte pairs
// assumes converter answers one conv_done pulse per start; file write takes one cycle
`timescale 1ns/1ns
`include "csdma_map.svh"
module csdma_seq
    import csdma_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [3:0] last_input,
    input wire logic [6:0] base,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output csdma_conv_t conv,
    output csdma_wr_t wr,
    output logic [3:0] cur_input,
    output logic scan_done
);
    csdma_state_t state_r;
    logic [3:0] cur_r;
    logic [9:0] res_r;

    function automatic logic [11:0] slot_addr(input logic [6:0] b, input logic [3:0] n, input logic odd);
        slot_addr = {b, n, odd};
    endfunction : slot_addr

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            state_r <= CS_IDLE;
            cur_r <= 4'h0;
        end else begin
            unique case (state_r)
                CS_IDLE: state_r <= CS_CONV;
                CS_CONV: state_r <= CS_WAIT;
                CS_WAIT: if (conv_done) begin
                    state_r <= CS_WR_HI;
                end
                CS_WR_HI: state_r <= CS_WR_LO;
                CS_WR_LO: begin
                    state_r <= CS_CONV;
                    // wrap to 0 after the last input; a shrunk count also wraps
                    if (cur_r >= last_input) begin
                        cur_r <= 4'h0;
                    end else begin
                        cur_r <= cur_r + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_r <= 10'h000;
        end else if (state_r == CS_WAIT && conv_done) begin
            res_r <= conv_result;
        end
    end

    always_comb begin
        conv.start = (state_r == CS_CONV);
        conv.input_sel = cur_r;
        wr.valid = (state_r == CS_WR_HI) || (state_r == CS_WR_LO);
        // msb byte at even address, two low bits at the odd one
        wr.addr = slot_addr(base, cur_r, state_r == CS_WR_LO);
        wr.data = (state_r == CS_WR_LO) ? {res_r[1:0], 6'h00} : res_r[9:2];
        scan_done = (state_r == CS_WR_LO) && (cur_r >= last_input);
    end
    assign cur_input = cur_r;

    a_store_pair: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == CS_WR_HI) && enable |=> wr.valid && wr.addr[0] && $past(wr.addr[11:1]) == wr.addr[11:1])
        else $error("low byte not at following odd address");
    a_disable_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> cur_r == 4'h0 && state_r == CS_IDLE)
        else $error("disabled scan not reset to input 0");
    a_addr_form: assert property (@(posedge aclk) disable iff (!aresetn)
        wr.valid |-> wr.addr[11:5] == base && wr.addr[4:1] == cur_r)
        else $error("store address malformed");
    a_conv_first: assert property (@(posedge aclk) disable iff (!aresetn)
        conv.start && enable |=> state_r == CS_WAIT)
        else $error("conversion start not followed by wait");
endmodule : csdma_seq

// *** verilog/csdma_top.sv ***
// converter-scan dma channel, general channel end bytes and shared status
// assumes an axi4-lite master, one converter and a one-cycle register-file write port
//
// Summary of operation
// - end address per general channel is high nibble joined above end low byte.
// - store address is base bits 7..1, input number, then zero for the msb byte, one for the rest.
// - result stored as msb byte at even address, rest at odd.
// - enable bit low disables scanning and resets input number to zero.
// - interrupt enable gives an interrupt after last input; else none.
// - count field n scans inputs 0 through n, up to 11.
// - every scan starts at input 0 and ascends.
// - each input is converted first, then its result moved.
// - status bits 2,1,0 flag scan, channel 1, channel 0.
// - reading status clears the three flags after returning them.
// - status bits 7..4 show the input being converted.
// - scan flag sets once last input is stored with interrupt.
// - general channel flag sets when it finishes at its end address.
`timescale 1ns/1ns
`include "csdma_map.svh"
module csdma_top
    import csdma_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter
    output csdma_conv_t conv,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    // register-file write port
    output csdma_wr_t rf_wr,
    // general channel engines
    input wire logic ch0_done,
    input wire logic ch1_done,
    output logic [11:0] ch0_end_addr,
    output logic [11:0] ch1_end_addr,
    output logic irq
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ch0_end_r;
    logic [7:0] ch1_end_r;
    logic [7:0] end_hi_r;
    logic [7:0] base_r;
    logic [7:0] ctrl_r;
    logic [2:0] flags_r;
    logic [2:0] flags_nxt;
    logic [2:0] mask_r;
    logic [3:0] cur_input;
    logic scan_done;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic aw_have_r;
    logic w_have_r;
    logic [13:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic do_write;
    logic [11:0] wr_idx;

    function automatic logic [11:0] reg_index(input logic [13:0] byte_addr);
        reg_index = byte_addr[13:2];
    endfunction : reg_index

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 14'h0000;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (wr_idx)
                    `CSDMA_IDX_CH0_END, `CSDMA_IDX_CH1_END, `CSDMA_IDX_BASE, `CSDMA_IDX_CTRL,
                    `CSDMA_IDX_STAT, `CSDMA_IDX_END_HI, `CSDMA_IDX_IMASK, `CSDMA_IDX_IPEND:
                        s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // only byte lane 0 carries data; status is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch0_end_r <= 8'h00;
            ch1_end_r <= 8'h00;
            end_hi_r <= 8'h00;
            base_r <= 8'h00;
            ctrl_r <= `CSDMA_CTRL_RESET;
            mask_r <= 3'h7;
        end else if (do_write && w_strb_r[0]) begin
            unique case (wr_idx)
                `CSDMA_IDX_CH0_END: ch0_end_r <= w_data_r[7:0];
                `CSDMA_IDX_CH1_END: ch1_end_r <= w_data_r[7:0];
                `CSDMA_IDX_END_HI: end_hi_r <= w_data_r[7:0];
                `CSDMA_IDX_BASE: base_r <= {w_data_r[7:1], 1'b0};
                `CSDMA_IDX_CTRL: ctrl_r <= {w_data_r[7:6], 2'h0, w_data_r[3:0]};
                `CSDMA_IDX_IMASK: mask_r <= w_data_r[2:0];
                default: ;
            endcase
        end
    end

    assign ch0_end_addr = {end_hi_r[3:0], ch0_end_r};
    assign ch1_end_addr = {end_hi_r[7:4], ch1_end_r};

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic stat_read;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic [11:0] rd_idx;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = reg_index(s_axi_araddr);

    always_comb begin
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        unique case (rd_idx)
            `CSDMA_IDX_CH0_END: rd_byte = ch0_end_r;
            `CSDMA_IDX_CH1_END: rd_byte = ch1_end_r;
            `CSDMA_IDX_END_HI: rd_byte = end_hi_r;
            `CSDMA_IDX_BASE: rd_byte = base_r;
            `CSDMA_IDX_CTRL: rd_byte = ctrl_r;
            `CSDMA_IDX_STAT: rd_byte = {cur_input, 1'b0, flags_r};
            `CSDMA_IDX_IMASK: rd_byte = {5'h00, mask_r};
            `CSDMA_IDX_IPEND: rd_byte = {5'h00, flags_r & mask_r};
            default: rd_ok = 1'b0;
        endcase
    end

    assign stat_read = s_axi_arvalid && s_axi_arready && rd_idx == `CSDMA_IDX_STAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // shared flags and interrupt
    // ----------------------------------------------------------------
    // read captures the old value in rdata before this clear lands
    always_comb begin
        flags_nxt = stat_read ? 3'h0 : flags_r;
        if (scan_done && ctrl_r[`CSDMA_CTRL_IE]) begin
            flags_nxt[`CSDMA_STAT_SCAN] = 1'b1;
        end
        if (ch1_done) begin
            flags_nxt[`CSDMA_STAT_CH1] = 1'b1;
        end
        if (ch0_done) begin
            flags_nxt[`CSDMA_STAT_CH0] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= 3'h0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign irq = |(flags_r & mask_r);

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    csdma_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ctrl_r[`CSDMA_CTRL_EN]),
        .last_input(ctrl_r[3:0] > `CSDMA_MAX_INPUT ? `CSDMA_MAX_INPUT : ctrl_r[3:0]),
        .base(base_r[7:1]),
        .conv_done(conv_done),
        .conv_result(conv_result),
        .conv(conv),
        .wr(rf_wr),
        .cur_input(cur_input),
        .scan_done(scan_done)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_read && !scan_done && !ch0_done && !ch1_done |=> flags_r == 3'h0)
        else $error("status read did not clear flags");
    a_event_survives: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_read && ch0_done |=> flags_r[0])
        else $error("channel 0 event lost during read");
    a_scan_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_done && ctrl_r[6] |=> flags_r[2])
        else $error("scan flag not set after last input");
    a_no_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_r[`CSDMA_CTRL_IE] && !flags_r[`CSDMA_STAT_SCAN] |=> !flags_r[`CSDMA_STAT_SCAN])
        else $error("scan flag set with interrupt disabled");
    a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        flags_r[1] && !stat_read |=> flags_r[1])
        else $error("channel 1 flag dropped without read");
    a_stat_shape: assert property (@(posedge aclk) disable iff (!aresetn)
        stat_read |=> s_axi_rvalid && s_axi_rdata[7:4] == $past(cur_input) && s_axi_rdata[2:0] == $past(flags_r))
        else $error("status read content wrong");
    a_end_join: assert property (@(posedge aclk) disable iff (!aresetn)
        ch1_end_addr[11:8] == end_hi_r[7:4] && ch0_end_addr[7:0] == ch0_end_r)
        else $error("end address join wrong");
endmodule : csdma_top

// *** verif/csdma_adc_model.sv ***
// converter model facing the scan sequencer
// assumes one start pulse per conversion; delay and value come from the bench
`timescale 1ns/1ns
module csdma_adc_model
    import csdma_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire csdma_conv_t conv,
    input wire logic [9:0] res_in,
    input wire logic [7:0] dly,
    output logic conv_done,
    output logic [9:0] conv_result
);
    logic busy;
    logic [7:0] cnt;
    logic [9:0] hold;
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        // result bus is garbage outside the done pulse
        conv_result <= ~conv_result;
        if (!aresetn) begin
            busy <= 1'b0;
            conv_result <= 10'h000;
        end else if (conv.start) begin
            busy <= 1'b1;
            cnt <= dly;
            hold <= res_in;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            conv_result <= hold;
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : csdma_adc_model

// *** verif/tb.sv ***
// self-checking bench of the converter-scan dma top
// assumes the converter model and a one-cycle register-file port
`timescale 1ns/1ns
`include "csdma_map.svh"
module tb
    import csdma_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, ch0_done = 1'b0, ch1_done = 1'b0;
    logic [13:0] awaddr = 14'h0, araddr = 14'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [9:0] res_in = 10'h0, conv_result, exp_res;
    logic [7:0] dly = 8'h00, m_ctrl = 8'h00, m_base = 8'h00, m_mask = 8'h07;
    logic awready, wready, bvalid, arready, rvalid, conv_done, irq;
    logic [1:0] bresp, rresp;
    logic [11:0] ch0_end_addr, ch1_end_addr;
    logic [3:0] exp_in = 4'h0, cur_snap, lastn;
    logic [2:0] flags = 3'h0, snap;
    csdma_conv_t conv;
    csdma_wr_t rf_wr;
    int bad_count = 0, samples_checked = 0, seed = 2152, phase = 0, nstore = 0;
    always #50 aclk = ~aclk;
    always @(posedge aclk) res_in <= 10'($random(seed));
    csdma_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv(conv),
        .conv_done(conv_done), .conv_result(conv_result), .rf_wr(rf_wr), .ch0_done(ch0_done),
        .ch1_done(ch1_done), .ch0_end_addr(ch0_end_addr), .ch1_end_addr(ch1_end_addr), .irq(irq));
    csdma_adc_model u_adc (.aclk(aclk), .aresetn(aresetn), .conv(conv), .res_in(res_in), .dly(dly),
        .conv_done(conv_done), .conv_result(conv_result));
    // ----------------------------------------------------------------
    // compare and bus tasks
    // ----------------------------------------------------------------
    task automatic fail(input string s);
        bad_count++;
        $display("Error at %0t: %s", $time, s);
    endtask : fail
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("read data %h expected %h", g, e));
    endtask : chk_rd
    task automatic chk_wr(input csdma_wr_t g, input logic [11:0] a, input logic [7:0] d);
        samples_checked++;
        if (g !== {1'b1, a, d}) fail($sformatf("store %h:%h expected %h:%h", g.addr, g.data, a, d));
    endtask : chk_wr
    task automatic chk_out(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("output %h expected %h", g, e));
    endtask : chk_out
    task automatic chk_irq;
        repeat (2) @(posedge aclk);
        // look once the edge's register updates have settled
        #1;
        chk_out(12'(irq), 12'(|(flags & m_mask[2:0])));
    endtask : chk_irq
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        int n;
        // one edge between calls, so no strobe is assigned twice in a time step
        @(posedge aclk);
        n = 0;
        hb = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb && n < 200) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bready && bvalid;
            if (hb) chk_out(12'(bresp), 12'(er));
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
            n++;
        end
        if (!hb) fail("write response missing");
        if (idx == `CSDMA_IDX_CTRL) begin
            m_ctrl = d;
            lastn = (d[3:0] > `CSDMA_MAX_INPUT) ? `CSDMA_MAX_INPUT : d[3:0];
        end
        if (idx == `CSDMA_IDX_CTRL && !d[`CSDMA_CTRL_EN]) begin
            exp_in = 4'h0;
            phase = 0;
        end
        if (idx == `CSDMA_IDX_BASE) m_base = d;
        if (idx == `CSDMA_IDX_IMASK) m_mask = d;
    endtask : wr
    task automatic rd(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er, input logic c0);
        logic ha, hr;
        logic [31:0] got;
        int n;
        @(posedge aclk);
        n = 0;
        hr = 1'b0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        ch0_done <= c0;
        while (!hr && n < 200) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rready && rvalid;
            got = rdata;
            if (hr) chk_out(12'(rresp), 12'(er));
            @(posedge aclk);
            ch0_done <= 1'b0;
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
            n++;
        end
        if (!hr) fail("read response missing");
        if (idx == `CSDMA_IDX_STAT) e = {cur_snap, 1'b0, snap};
        chk_rd(got, {24'h000000, e});
    endtask : rd
    task automatic wait_for(input int t, input int ph);
        for (int i = 0; i < 5000 && (nstore < t || (ph >= 0 && phase != ph)); i++) @(posedge aclk);
        if (nstore < t || (ph >= 0 && phase != ph)) fail("scan stalled");
    endtask : wait_for
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // behavioural scan model, checked at every store and start
    // ----------------------------------------------------------------
    always @(negedge aclk) begin : mon
        logic [2:0] ev;
        ev = {1'b0, ch1_done, ch0_done};
        if (aresetn) begin
            if (conv.start) begin
                chk_out(12'(phase), 12'h000);
                chk_out(12'(conv.input_sel), 12'(exp_in));
                exp_res = res_in;
                phase = 1;
            end
            if (rf_wr.valid && phase == 2) begin
                chk_wr(rf_wr, {m_base[7:1], exp_in, 1'b1}, {exp_res[1:0], 6'h00});
                phase = 0;
                nstore++;
                if (exp_in >= lastn) begin
                    exp_in = 4'h0;
                    ev[2] = m_ctrl[`CSDMA_CTRL_IE];
                end else exp_in++;
            end else if (rf_wr.valid) begin
                chk_out(12'(phase), 12'h001);
                chk_wr(rf_wr, {m_base[7:1], exp_in, 1'b0}, exp_res[9:2]);
                phase = 2;
            end
            if (arvalid && arready && araddr == {`CSDMA_IDX_STAT, 2'b00}) begin
                snap = flags;
                cur_snap = exp_in;
                flags = 3'h0;
            end
            flags |= ev;
        end
    end
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin : main
        logic [7:0] n;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CSDMA_IDX_CTRL, `CSDMA_CTRL_RESET, 2'b00, 1'b0);
        rd(`CSDMA_IDX_STAT, 8'h00, 2'b00, 1'b0);
        rd(`CSDMA_IDX_IMASK, 8'h07, 2'b00, 1'b0);
        rd(12'hfc3, 8'h00, 2'b10, 1'b0);
        wr(12'hfc3, 8'h11, 2'b10);
        wr(`CSDMA_IDX_CH0_END, 8'h5a, 2'b00);
        wr(`CSDMA_IDX_CH1_END, 8'ha5, 2'b00);
        wr(`CSDMA_IDX_END_HI, 8'h3c, 2'b00);
        chk_out(ch0_end_addr, 12'hc5a);
        chk_out(ch1_end_addr, 12'h3a5);
        rd(`CSDMA_IDX_CH1_END, 8'ha5, 2'b00, 1'b0);
        wr(`CSDMA_IDX_BASE, 8'h72, 2'b00);
        for (int k = 0; k < 13; k++) begin
            n = (k == 12) ? 8'h0f : 8'(k);
            dly <= k[0] ? 8'h00 : 8'h1e;
            wr(`CSDMA_IDX_CTRL, {1'b1, k != 5, 2'b00, n[3:0]}, 2'b00);
            wait_for(nstore + lastn + 2, -1);
            chk_irq;
            dly <= 8'h3c;
            wait_for(nstore + 1, 1);
            rd(`CSDMA_IDX_STAT, 8'h00, 2'b00, 1'b0);
            chk_irq;
            wr(`CSDMA_IDX_CTRL, 8'h00, 2'b00);
            repeat (80) @(posedge aclk);
            rd(`CSDMA_IDX_STAT, 8'h00, 2'b00, 1'b0);
        end
        ch1_done <= 1'b1;
        @(posedge aclk);
        ch1_done <= 1'b0;
        chk_irq;
        wr(`CSDMA_IDX_STAT, 8'hff, 2'b00);
        wr(`CSDMA_IDX_IMASK, 8'h05, 2'b00);
        chk_irq;
        rd(`CSDMA_IDX_IPEND, 8'h00, 2'b00, 1'b0);
        wr(`CSDMA_IDX_IMASK, 8'h07, 2'b00);
        rd(`CSDMA_IDX_IPEND, 8'h02, 2'b00, 1'b0);
        rd(`CSDMA_IDX_STAT, 8'h00, 2'b00, 1'b1);
        rd(`CSDMA_IDX_STAT, 8'h00, 2'b00, 1'b0);
        chk_irq;
        summarize;
    end
    initial begin : watchdog
        #(100 * 80000);
        bad_count++;
        summarize;
    end
endmodule : tb
